// ===== src/amo_pkg.sv
package amo_pkg;
   // ---------------------------------------------------------------
   // Register map (byte addresses, word aligned)
   // ---------------------------------------------------------------
   localparam logic [7:0] ADR_OPTION = 8'h00;
   localparam logic [7:0] ADR_STATUS = 8'h04;
   localparam logic [7:0] ADR_COND   = 8'h08;
   localparam logic [7:0] ADR_IRQST  = 8'h0C;
   localparam logic [7:0] ADR_IRQMSK = 8'h10;
   localparam logic [7:0] ADR_CMD    = 8'h14;
   localparam logic [7:0] ADR_ERRLIM = 8'h18;

   // ---------------------------------------------------------------
   // Option word weights (bit positions)
   // ---------------------------------------------------------------
   localparam int OPT_RETGT_RESET = 0;
   localparam int OPT_LOCK_EN     = 1;
   localparam int OPT_RETGT_FAIL  = 2;
   localparam int OPT_RESERVED    = 3;
   localparam int OPT_MUTE_INV    = 4;
   localparam int OPT_REL_AZ      = 5;
   localparam int OPT_LNB_EN      = 6;
   localparam int OPT_LOCK_INV    = 7;
   localparam logic [7:0] OPTION_RST = 8'h00;

   // Condition register bits
   localparam int CND_BLOCKED = 0;
   localparam int CND_SEARCH  = 1;
   localparam int CND_TARGET  = 2;
   localparam int CND_UNWRAP  = 3;

   // Command register bits (write one to act)
   localparam int CMD_APPLY  = 0;
   localparam int CMD_SAVE   = 1;
   localparam int CMD_FRESET = 2;
   localparam int CMD_INITOK = 3;
   localparam int CMD_SFAIL  = 4;

   // Interrupt status bits
   localparam int IRQ_MUTE_CHG = 0;
   localparam int IRQ_LOCK_ACQ = 1;
   localparam int IRQ_RETARGET = 2;
   localparam int IRQ_SFAIL    = 3;
   localparam int IRQ_W        = 4;

   // Pointing error thresholds, hundredths of a degree
   localparam logic [15:0] ERR_MUTE_CDEG   = 16'h0032; // 0.50 deg
   localparam logic [15:0] ERR_UNMUTE_CDEG = 16'h0014; // 0.20 deg

   // Search failure actions
   typedef enum logic [1:0] {
      AMO_ACT_NONE   = 2'b00,
      AMO_ACT_ORIGIN = 2'b01,
      AMO_ACT_RETGT  = 2'b11
   } amo_act_e;
endpackage : amo_pkg

// ===== src/amo_mute_if.sv
`timescale 1ns/10ps
// Mute condition bundle between the top and the mute evaluator
interface amo_mute_if;
   logic        blocked;
   logic        searching;
   logic        targeting;
   logic        unwrapping;
   logic [15:0] point_err;
   logic        invert;
   logic        mute_active;
   logic        mispoint_hold;
   modport ctrl (output blocked, output searching, output targeting,
                 output unwrapping, output point_err, output invert,
                 input mute_active, input mispoint_hold);
   modport eval (input blocked, input searching, input targeting,
                 input unwrapping, input point_err, input invert,
                 output mute_active, output mispoint_hold);
endinterface : amo_mute_if

// ===== src/amo_mute_eval.sv
`timescale 1ns/10ps
module amo_mute_eval (
   input  wire logic    clk_i,
   input  wire logic    rst_i,
   amo_mute_if.eval     mif
);
   logic hold_q;
   logic mute_q;
   logic raw_mute;

   // ------------------------------------------------------------
   // Mispoint hysteresis: set at 0.5, release at 0.2
   // ------------------------------------------------------------
   // hold until 0.2
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         hold_q <= 1'b0;
      end else if (mif.point_err >= amo_pkg::ERR_MUTE_CDEG) begin
         hold_q <= 1'b1;
      end else if (mif.point_err <= amo_pkg::ERR_UNMUTE_CDEG) begin
         hold_q <= 1'b0;
      end
   end

   assign raw_mute = mif.blocked | mif.searching | mif.targeting |
                     mif.unwrapping | hold_q |
                     (mif.point_err >= amo_pkg::ERR_MUTE_CDEG);

   // Registered each clock so the output follows within one cycle
   // continuous evaluation
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mute_q <= 1'b1; // Muted until conditions are known
      end else begin
         mute_q <= raw_mute;
      end
   end

   assign mif.mute_active   = mute_q;
   assign mif.mispoint_hold = hold_q;
endmodule : amo_mute_eval

// ===== src/amo_option_ctrl.sv
`timescale 1ns/10ps
// ------------------------------------------------------------------
// Overview of operation
// - Mute unless out of zones, not searching/targeting, error below 0.5.
// - Weight 16 inverts mute output polarity: high means blocked.
// - Lock input ignored unless weight 2 set; off by default.
// - Weight 128 makes high on lock input mean locked.
// - Lock indication used only during search, never for tracking.
// - LNB supply output driven only when weight 64 set.
// - Weight 32 shows relative azimuth instead of tracking signal.
// - Search failure returns to origin by default, no retarget.
// - Weight 4 retargets calculated satellite after search failure.
// - Weight 1 retargets after power-up init and front-panel reset.
// - Option word is sum of independent weights.
// - Edited option applied on confirm; separate save persists it.
// - Mispoint mute holds until error within 0.2 degrees.
// - Unwrapping also asserts the mute output.
// ------------------------------------------------------------------
module amo_option_ctrl #(
   parameter int ERR_W = 16
) (
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   // Wishbone classic slave
   input  wire logic             wb_cyc_i,
   input  wire logic             wb_stb_i,
   input  wire logic             wb_we_i,
   input  wire logic [7:0]       wb_adr_i,
   input  wire logic [3:0]       wb_sel_i,
   input  wire logic [31:0]      wb_dat_i,
   output logic      [31:0]      wb_dat_o,
   output logic                  wb_ack_o,
   output logic                  wb_err_o,
   // Antenna state
   input  wire logic             in_zone_i,
   input  wire logic [ERR_W-1:0] point_err_i,
   input  wire logic             power_up_i,
   // Modem discrete lines
   input  wire logic             external_lock_input_i,
   output logic                  mute_blockage_output_o,
   // Derived controls
   output logic                  lnb_supply_en_o,
   output logic                  relative_azimuth_o,
   output logic                  sat_locked_o,
   output logic                  retarget_o,
   output logic                  return_origin_o,
   output logic                  save_req_o,
   output logic                  irq_o
);
   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   localparam int IRQ_W_L = amo_pkg::IRQ_W;

   logic [7:0]        edit_q;     // Pending option word
   logic [7:0]        option_q;   // Active option word
   logic [3:0]        cond_q;     // Software-driven conditions
   logic [IRQ_W_L-1:0] irq_st_q;
   logic [IRQ_W_L-1:0] irq_msk_q;
   logic [IRQ_W_L-1:0] irq_ev;
   logic              ack_q;
   logic [31:0]       rdat_q;
   logic              wr_stb;
   logic              rd_stb;
   logic              hit;
   logic              mute_q;
   logic              mute_prev_q;
   logic              lock_q;
   logic              lock_prev_q;
   logic              retgt_q;
   logic              origin_q;
   logic              save_q;
   logic              pwr_pend_q;
   logic              lock_raw;
   logic              lock_use;
   logic              init_ok;
   logic              freset;
   logic              sfail;
   amo_pkg::amo_act_e fail_act;

   amo_mute_if mif ();

   // ---------------------------------------------------------------
   // Byte-lane write merge
   // ---------------------------------------------------------------
   function automatic logic [7:0] lane0(input logic [7:0] old,
                                        input logic [3:0] sel,
                                        input logic [31:0] dat);
      lane0 = sel[0] ? dat[7:0] : old;
   endfunction : lane0

   // ---------------------------------------------------------------
   // Bus decode
   // ---------------------------------------------------------------
   assign hit = (wb_adr_i == amo_pkg::ADR_OPTION) ||
                (wb_adr_i == amo_pkg::ADR_STATUS) ||
                (wb_adr_i == amo_pkg::ADR_COND)   ||
                (wb_adr_i == amo_pkg::ADR_IRQST)  ||
                (wb_adr_i == amo_pkg::ADR_IRQMSK) ||
                (wb_adr_i == amo_pkg::ADR_CMD)    ||
                (wb_adr_i == amo_pkg::ADR_ERRLIM);
   assign wr_stb = wb_cyc_i & wb_stb_i & ~ack_q & wb_we_i & hit;
   assign rd_stb = wb_cyc_i & wb_stb_i & ~ack_q & ~wb_we_i;

   // One-wait answer; ack (or err when unmapped) for a single cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= wb_cyc_i & wb_stb_i & ~ack_q;
      end
   end
   // Unmapped address answered with err instead of ack
   logic unmap_q;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         unmap_q <= 1'b0;
      end else begin
         unmap_q <= ~hit;
      end
   end
   assign wb_ack_o = ack_q & ~unmap_q;
   assign wb_err_o = ack_q & unmap_q;

   // Command strobes, one cycle
   assign init_ok = wr_stb & (wb_adr_i == amo_pkg::ADR_CMD) & wb_sel_i[0]
                    & wb_dat_i[amo_pkg::CMD_INITOK];
   assign freset  = wr_stb & (wb_adr_i == amo_pkg::ADR_CMD) & wb_sel_i[0]
                    & wb_dat_i[amo_pkg::CMD_FRESET];
   assign sfail   = wr_stb & (wb_adr_i == amo_pkg::ADR_CMD) & wb_sel_i[0]
                    & wb_dat_i[amo_pkg::CMD_SFAIL];

   // ---------------------------------------------------------------
   // Option word: edit buffer and active copy
   // ---------------------------------------------------------------
   // sum of weights
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         edit_q <= amo_pkg::OPTION_RST;
      end else if (wr_stb && wb_adr_i == amo_pkg::ADR_OPTION) begin
         edit_q <= lane0(edit_q, wb_sel_i, wb_dat_i);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         option_q <= amo_pkg::OPTION_RST;
      end else if (wr_stb && wb_adr_i == amo_pkg::ADR_CMD &&
                   wb_sel_i[0] && wb_dat_i[amo_pkg::CMD_APPLY]) begin
         option_q <= edit_q;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         save_q <= 1'b0;
      end else begin
         save_q <= wr_stb & (wb_adr_i == amo_pkg::ADR_CMD) & wb_sel_i[0]
                   & wb_dat_i[amo_pkg::CMD_SAVE];
      end
   end
   assign save_req_o = save_q;

   // Conditions written by the pointing firmware
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cond_q <= 4'h0;
      end else if (wr_stb && wb_adr_i == amo_pkg::ADR_COND && wb_sel_i[0]) begin
         cond_q <= wb_dat_i[3:0];
      end
   end

   // ---------------------------------------------------------------
   // Mute evaluation
   // ---------------------------------------------------------------
   assign mif.blocked    = cond_q[amo_pkg::CND_BLOCKED] | in_zone_i;
   assign mif.searching  = cond_q[amo_pkg::CND_SEARCH];
   assign mif.targeting  = cond_q[amo_pkg::CND_TARGET];
   assign mif.unwrapping = cond_q[amo_pkg::CND_UNWRAP];
   assign mif.point_err  = 16'(point_err_i);
   assign mif.invert     = option_q[amo_pkg::OPT_MUTE_INV];

   amo_mute_eval u_eval (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .mif   (mif)
   );

   // Output high means open; default grounds (low) when muted
   // polarity invert
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mute_q <= 1'b0;
      end else begin
         mute_q <= mif.invert ? mif.mute_active : ~mif.mute_active;
      end
   end
   assign mute_blockage_output_o = mute_q;
   // weight 8 unused
   // Reserved bit decodes to nothing; only stored for read-back

   // ---------------------------------------------------------------
   // Lock input
   // ---------------------------------------------------------------
   // reversed polarity
   assign lock_raw = option_q[amo_pkg::OPT_LOCK_INV] ? external_lock_input_i
                                                     : ~external_lock_input_i;
   assign lock_use = option_q[amo_pkg::OPT_LOCK_EN] &
                     cond_q[amo_pkg::CND_SEARCH] & lock_raw;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lock_q <= 1'b0;
      end else begin
         lock_q <= lock_use;
      end
   end
   assign sat_locked_o = lock_q;

   // Feature outputs, registered
   // LNB gate
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lnb_supply_en_o    <= 1'b0;
         relative_azimuth_o <= 1'b0;
      end else begin
         lnb_supply_en_o    <= option_q[amo_pkg::OPT_LNB_EN];
         relative_azimuth_o <= option_q[amo_pkg::OPT_REL_AZ];
      end
   end

   // ---------------------------------------------------------------
   // Search failure and retarget actions
   // ---------------------------------------------------------------
   // default origin
   always_comb begin
      case ({sfail, option_q[amo_pkg::OPT_RETGT_FAIL]})
         2'b10:   fail_act = amo_pkg::AMO_ACT_ORIGIN;
         2'b11:   fail_act = amo_pkg::AMO_ACT_RETGT;
         default: fail_act = amo_pkg::AMO_ACT_NONE;
      endcase
   end

   // Power-up request waits for antenna initialisation to finish
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pwr_pend_q <= 1'b0;
      end else if (init_ok) begin
         pwr_pend_q <= 1'b0;
      end else if (power_up_i) begin
         pwr_pend_q <= 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         retgt_q  <= 1'b0;
         origin_q <= 1'b0;
      end else begin
         retgt_q  <= (fail_act == amo_pkg::AMO_ACT_RETGT) |
                     (option_q[amo_pkg::OPT_RETGT_RESET] &
                      (freset | (init_ok & pwr_pend_q)));
         origin_q <= (fail_act == amo_pkg::AMO_ACT_ORIGIN);
      end
   end
   assign retarget_o      = retgt_q;
   assign return_origin_o = origin_q;

   // ---------------------------------------------------------------
   // Interrupts: sticky status, write one to clear, set wins
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mute_prev_q <= 1'b0;
         lock_prev_q <= 1'b0;
      end else begin
         mute_prev_q <= mute_q;
         lock_prev_q <= lock_q;
      end
   end
   assign irq_ev[amo_pkg::IRQ_MUTE_CHG] = mute_q ^ mute_prev_q;
   assign irq_ev[amo_pkg::IRQ_LOCK_ACQ] = lock_q & ~lock_prev_q;
   assign irq_ev[amo_pkg::IRQ_RETARGET] = retgt_q;
   assign irq_ev[amo_pkg::IRQ_SFAIL]    = origin_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_st_q <= '0;
      end else if (wr_stb && wb_adr_i == amo_pkg::ADR_IRQST && wb_sel_i[0]) begin
         irq_st_q <= (irq_st_q & ~wb_dat_i[IRQ_W_L-1:0]) | irq_ev;
      end else begin
         irq_st_q <= irq_st_q | irq_ev;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_msk_q <= '0;
      end else if (wr_stb && wb_adr_i == amo_pkg::ADR_IRQMSK && wb_sel_i[0]) begin
         irq_msk_q <= wb_dat_i[IRQ_W_L-1:0];
      end
   end
   assign irq_o = |(irq_st_q & irq_msk_q);

   // ---------------------------------------------------------------
   // Read data
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdat_q <= 32'h0000_0000;
      end else if (rd_stb) begin
         case (wb_adr_i)
            amo_pkg::ADR_OPTION: rdat_q <= {24'h00_0000, edit_q};
            amo_pkg::ADR_STATUS: rdat_q <= {16'h0000, option_q, 3'h0,
                                  mif.mispoint_hold, lnb_supply_en_o,
                                  lock_q, mif.mute_active, mute_q};
            amo_pkg::ADR_COND:   rdat_q <= {28'h000_0000, cond_q};
            amo_pkg::ADR_IRQST:  rdat_q <= {28'h000_0000, irq_st_q};
            amo_pkg::ADR_IRQMSK: rdat_q <= {28'h000_0000, irq_msk_q};
            amo_pkg::ADR_ERRLIM: rdat_q <= {amo_pkg::ERR_UNMUTE_CDEG,
                                            amo_pkg::ERR_MUTE_CDEG};
            default:             rdat_q <= 32'h0000_0000;
         endcase
      end
   end
   assign wb_dat_o = rdat_q;
endmodule : amo_option_ctrl

// ===== testbench/amo_modem_model.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// Modem stand-in: lock line out, mute line in
// ------------------------------------------------------------
module amo_modem_model (
   input  wire logic clk_i,
   input  wire logic locked_i,
   input  wire logic lock_high_i,
   input  wire logic mute_line_i,
   input  wire logic mute_open_i,
   output logic      lock_line_o,
   output logic      tx_muted_o
);
   // low line while locked
   // Line moves one edge after the receiver state, like a real modem
   always_ff @(posedge clk_i) begin
      lock_line_o <= lock_high_i ? locked_i : ~locked_i;
   end
   // Transmit held off when the mute line reads blocked
   assign tx_muted_o = mute_open_i ? mute_line_i : ~mute_line_i;
endmodule : amo_modem_model

// ===== testbench/amo_option_ctrl_properties.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// Port checker
// ------------------------------------------------------------
module amo_option_props #(
   parameter int ERR_W = 16
) (
   input wire logic             clk_i,
   input wire logic             rst_i,
   input wire logic             wb_cyc_i,
   input wire logic             wb_stb_i,
   input wire logic             wb_we_i,
   input wire logic [7:0]       wb_adr_i,
   input wire logic [31:0]      wb_dat_i,
   input wire logic             wb_ack_o,
   input wire logic             wb_err_o,
   input wire logic             in_zone_i,
   input wire logic [ERR_W-1:0] point_err_i,
   input wire logic             mute_blockage_output_o,
   input wire logic             lnb_supply_en_o,
   input wire logic             sat_locked_o,
   input wire logic             retarget_o,
   input wire logic             return_origin_o
);
   logic [7:0] edit_q;
   logic [7:0] act_q;
   logic [3:0] cond_q;
   logic [2:0] age_q;
   logic       req;
   logic       wr;
   logic       inv;
   // Request taken at this edge
   assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
   assign wr  = req & wb_we_i;
   assign inv = act_q[amo_pkg::OPT_MUTE_INV];
   // Shadow of option and condition registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         edit_q <= amo_pkg::OPTION_RST;
         act_q  <= amo_pkg::OPTION_RST;
         cond_q <= 4'h0;
      end else begin
         if (wr && wb_adr_i == amo_pkg::ADR_OPTION) edit_q <= wb_dat_i[7:0];
         if (wr && wb_adr_i == amo_pkg::ADR_COND) cond_q <= wb_dat_i[3:0];
         if (wr && wb_adr_i == amo_pkg::ADR_CMD && wb_dat_i[0]) act_q <= edit_q;
      end
   end
   // Cycles since apply; outputs lag the option, so wait it out
   always_ff @(posedge clk_i) begin
      if (rst_i || (wr && wb_adr_i == amo_pkg::ADR_CMD && wb_dat_i[0])) begin
         age_q <= 3'h0;
      end else if (age_q != 3'h7) begin
         age_q <= age_q + 3'h1;
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_ack_answer: assert property (req && wb_adr_i <= amo_pkg::ADR_ERRLIM
      && wb_adr_i[1:0] == 2'h0 |=> wb_ack_o && !wb_err_o)
      else $error("bus ack missing");
   a_err_unmapped: assert property (req && !(wb_adr_i[1:0] == 2'h0 &&
      wb_adr_i <= amo_pkg::ADR_ERRLIM) |=> wb_err_o && !wb_ack_o)
      else $error("bus err missing");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_zone_mutes: assert property (
      (age_q == 3'h7 && in_zone_i)[*4] |-> mute_blockage_output_o == inv)
      else $error("zone did not mute");
   a_mispoint_mutes: assert property (
      (age_q == 3'h7 && point_err_i >= amo_pkg::ERR_MUTE_CDEG)[*4]
      |-> mute_blockage_output_o == inv) else $error("mispoint not muted");
   a_cond_mutes: assert property (
      (age_q == 3'h7 && cond_q != 4'h0)[*4]
      |-> mute_blockage_output_o == inv) else $error("condition not muted");
   a_clear_opens: assert property (
      (age_q == 3'h7 && !in_zone_i && cond_q == 4'h0 &&
       point_err_i <= amo_pkg::ERR_UNMUTE_CDEG)[*4]
      |-> mute_blockage_output_o == !inv) else $error("clear still muted");
   a_lnb_follows: assert property (
      age_q >= 3'h3 |-> lnb_supply_en_o == act_q[amo_pkg::OPT_LNB_EN])
      else $error("lnb not per option");
   a_lock_ignored: assert property (
      age_q >= 3'h3 && !act_q[amo_pkg::OPT_LOCK_EN] |-> !sat_locked_o)
      else $error("lock used while disabled");
   a_fail_action: assert property (
      wr && wb_adr_i == amo_pkg::ADR_CMD && wb_dat_i[4] && age_q >= 3'h3
      |-> ##[1:2] (act_q[amo_pkg::OPT_RETGT_FAIL] ? retarget_o
                   : return_origin_o)) else $error("fail action wrong");
   a_origin_alone: assert property (
      return_origin_o |-> !retarget_o) else $error("origin with retarget");
   c_unmapped: cover property (req && wb_adr_i > amo_pkg::ADR_ERRLIM);
   c_retarget: cover property (retarget_o);
   c_origin: cover property (return_origin_o);
   c_unmute: cover property ($rose(mute_blockage_output_o));
endmodule : amo_option_props

bind amo_option_ctrl amo_option_props #(
   .ERR_W(ERR_W)
) u_props (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
   .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .in_zone_i(in_zone_i),
   .point_err_i(point_err_i), .mute_blockage_output_o(mute_blockage_output_o),
   .lnb_supply_en_o(lnb_supply_en_o), .sat_locked_o(sat_locked_o),
   .retarget_o(retarget_o), .return_origin_o(return_origin_o)
);

// ===== testbench/tb_antenna_mute_option_control.sv
`timescale 1ns/10ps
module tb_antenna_mute_option_control;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, zone = 1'b0, pwr = 1'b0;
   logic [7:0]  adr = 8'h00, opt = 8'h00, o;
   logic [31:0] wdat = 32'h0, rd, dat_o;
   logic [15:0] perr = 16'h0000;
   logic        ack, err_o, err, mute, lnb, relaz, locked, retgt, origin;
   logic        save, irq, line, mlock = 1'b0, tx_muted;
   int num_errors = 0, check_count = 0, cycles = 0, n_rt = 0, n_or = 0;
   int n_sv = 0, a, b;
   logic [15:0] hys [8] = '{49, 50, 30, 21, 20, 49, 60, 0};
   logic        hys_m [8] = '{0, 1, 1, 1, 0, 0, 1, 0};

   always #5 clk_i = ~clk_i;

   amo_option_ctrl u_dut (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
      .wb_dat_o(dat_o), .wb_ack_o(ack), .wb_err_o(err_o), .in_zone_i(zone),
      .point_err_i(perr), .power_up_i(pwr), .external_lock_input_i(line),
      .mute_blockage_output_o(mute), .lnb_supply_en_o(lnb),
      .relative_azimuth_o(relaz), .sat_locked_o(locked), .retarget_o(retgt),
      .return_origin_o(origin), .save_req_o(save), .irq_o(irq));
   amo_modem_model u_modem (
      .clk_i(clk_i), .locked_i(mlock), .lock_high_i(opt[7]),
      .mute_line_i(mute), .mute_open_i(opt[4]), .lock_line_o(line),
      .tx_muted_o(tx_muted));

   // Pulse counters and hang guard
   always @(posedge clk_i) begin
      cycles++;
      if (retgt === 1'b1) n_rt++;
      if (origin === 1'b1) n_or++;
      if (save === 1'b1) n_sv++;
      if (cycles == 20000) begin
         num_errors++;
         wrap_up();
      end
   end

   task automatic chk_bit(input string nm, input logic e, input logic g);
      check_count++;
      if (g !== e) begin
         num_errors++;
         $display("MISMATCH %s exp %b got %b", nm, e, g);
      end
   endtask : chk_bit

   task automatic chk_word(input string nm, input logic [31:0] e,
                           input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         num_errors++;
         $display("MISMATCH %s exp %h got %h", nm, e, g);
      end
   endtask : chk_word

   // Classic single cycle; wait for ack or err under a bound
   task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] d);
      int n = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= ad;
      wdat <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && err_o !== 1'b1 && n < 20);
      chk_bit("bus_answer", 1'b1, n < 20);
      rd = dat_o;
      err = err_o;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask : wb

   task automatic settle();
      repeat (4) @(posedge clk_i);
   endtask : settle

   task automatic set_opt(input logic [7:0] v);
      wb(1'b1, amo_pkg::ADR_OPTION, {24'h0, v});
      wb(1'b1, amo_pkg::ADR_CMD, 32'h1);
      opt <= v;
      settle();
   endtask : set_opt

   // Pin level for a muted or clear state under an option word
   function automatic logic exp_pin(input logic m, input logic [7:0] v);
      return m ? v[amo_pkg::OPT_MUTE_INV] : ~v[amo_pkg::OPT_MUTE_INV];
   endfunction : exp_pin

   task automatic wrap_up();
      if (num_errors == 0 && check_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : wrap_up

   initial begin
      void'($urandom(32'hC7BC));
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b0, amo_pkg::ADR_OPTION, 32'h0);
      chk_word("option_rst", 32'h0, rd);
      wb(1'b1, 8'h40, 32'hFF);
      chk_bit("unmapped_err", 1'b1, err);
      wb(1'b0, 8'h40, 32'h0);
      chk_word("unmapped_rd", 32'h0, rd);
      // Edit, save, then apply
      wb(1'b1, amo_pkg::ADR_OPTION, 32'h40);
      wb(1'b1, amo_pkg::ADR_CMD, 32'h2);
      settle();
      chk_bit("lnb_unapplied", 1'b0, lnb);
      chk_word("save_pulses", 32'd1, n_sv);
      set_opt(8'h40);
      chk_bit("lnb_applied", 1'b1, lnb);
      // Option words: corners then random
      for (int i = 0; i < 10; i++) begin
         o = (i == 0) ? 8'h08 : (i == 1) ? 8'hFF : 8'($urandom);
         set_opt(o);
         chk_bit("lnb", o[6], lnb);
         chk_bit("rel_az", o[5], relaz);
         chk_bit("pin_clear", exp_pin(1'b0, o), mute);
         wb(1'b0, amo_pkg::ADR_STATUS, 32'h0);
         chk_word("active_opt", {24'h0, o}, {24'h0, rd[15:8]});
      end
      // Each condition bit and the zone input under both pin polarities
      for (int p = 0; p < 2; p++) begin
         set_opt(8'(p << 4));
         for (int c = 0; c < 5; c++) begin
            if (c < 4) wb(1'b1, amo_pkg::ADR_COND, 32'(1 << c));
            else zone <= 1'b1;
            settle();
            chk_bit("pin_muted", exp_pin(1'b1, opt), mute);
            chk_bit("tx_muted", 1'b1, tx_muted);
            wb(1'b1, amo_pkg::ADR_COND, 32'h0);
            zone <= 1'b0;
            settle();
            chk_bit("pin_open", exp_pin(1'b0, opt), mute);
         end
      end
      // Pointing error hysteresis, 0.5 to mute and 0.2 to clear
      for (int i = 0; i < 8; i++) begin
         @(posedge clk_i);
         perr <= hys[i];
         settle();
         chk_bit("pin_mispoint", exp_pin(hys_m[i], opt), mute);
      end
      // Lock use: enable, polarity, searching, modem state
      for (int k = 0; k < 16; k++) begin
         set_opt({k[1], 5'h0, k[0], 1'b0});
         wb(1'b1, amo_pkg::ADR_COND, {30'h0, k[2], 1'b0});
         mlock <= k[3];
         settle();
         chk_bit("sat_locked", k[0] & k[2] & k[3], locked);
      end
      wb(1'b1, amo_pkg::ADR_COND, 32'h0);
      // Search failure and reset retargeting
      for (int f = 0; f < 2; f++) begin
         set_opt(8'(f << 2));
         a = n_rt;
         b = n_or;
         wb(1'b1, amo_pkg::ADR_CMD, 32'h10);
         settle();
         chk_word("fail_retgt", 32'(f), 32'(n_rt - a));
         chk_word("fail_origin", 32'(1 - f), 32'(n_or - b));
         set_opt(8'(f));
         a = n_rt;
         wb(1'b1, amo_pkg::ADR_CMD, 32'h4);
         pwr <= 1'b1;
         settle();
         pwr <= 1'b0;
         wb(1'b1, amo_pkg::ADR_CMD, 32'h8);
         settle();
         chk_word("reset_retgt", 32'(2 * f), 32'(n_rt - a));
      end
      // Interrupt: raise, clear, mask
      wb(1'b1, amo_pkg::ADR_IRQST, 32'hF);
      wb(1'b1, amo_pkg::ADR_IRQMSK, 32'h1);
      zone <= 1'b1;
      settle();
      chk_bit("irq_raised", 1'b1, irq);
      wb(1'b1, amo_pkg::ADR_IRQST, 32'h1);
      settle();
      chk_bit("irq_cleared", 1'b0, irq);
      wb(1'b1, amo_pkg::ADR_IRQMSK, 32'h0);
      zone <= 1'b0;
      settle();
      chk_bit("irq_masked", 1'b0, irq);
      wb(1'b0, amo_pkg::ADR_IRQST, 32'h0);
      chk_bit("irq_sticky", 1'b1, rd[0]);
      wrap_up();
   end
endmodule : tb_antenna_mute_option_control
